// ==== include/breaker_defines.svh ====
// Constants for the breaker synchronize, unload and open control.
// Assumes inclusion by bare name from the design files.
`ifndef BREAKER_DEFINES_SVH
`define BREAKER_DEFINES_SVH

// Channel indices in the per-breaker vectors
`define CH_A 0
`define CH_B 1
// Number of breakers handled
`define NUM_CH 2
// Number of pin inputs that pass the synchroniser
`define NUM_PIN 4
// Pin vector positions
`define PIN_KEY_A 0
`define PIN_KEY_B 1
`define PIN_FB_A 2
`define PIN_FB_B 3
// Reset values of outputs and flags
`define RST_OFF 1'b0
// Default width of the device number on the shared bus
`define DEV_NUM_W_DEF 6

`endif

// ==== include/breaker_pkg.sv ====
// Types shared by the breaker control modules.
// Assumes breaker_defines.svh is on the include path.
package breaker_pkg;
	// Per-breaker sequence state
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_UNLOAD,
		ST_OPEN
	} brk_state_e;
endpackage

// ==== include/open_wish_if.sv ====
// Carrier between the breaker control and the open-wish arbiter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface open_wish_if;
	logic wish;
	logic grant;
	// Control publishes its wish and reads the grant
	modport ctrl (output wish, input grant);
	// Arbiter reads the wish and answers the grant
	modport arb (input wish, output grant);
endinterface

// ==== logic/breaker_ctrl.sv ====
// Synchronize, unload and open decisions for two breakers.
// Assumes equation inputs and settings are on clk; pins are not.
//
// Functional notes
// - Auto sync A: both systems in range, differences ok, enable, no open.
// - Manual sync A: conditions ok, close input or key, no manual open.
// - Two-breaker mode also needs breaker B closed to sync A.
// - Sync B only two-breaker mode with A closed, same trigger style.
// - Unload A only with two systems and a variable side, else open.
// - Auto unload on open_unload_a; abort when it drops with enable.
// - Manual unload per setting on manual open; abort with close input.
// - Soft key started unloading cannot be aborted and forces open.
// - Publish open wish; lowest device number passes execution on.
// - Open-failure alarm stops the unloading execution.
// - Relay A energizes to open when normally open, else de-energizes.
// - Open A on unload done, immediate, soft key or B key cross.
// - Open A on class C or higher alone, class C or D two-breaker.
// - Opening A complete when A feedback reports open.
// - Leave A open state when A in range, no C/D, close permit.
// - Relay B energizes to open when normally open, else de-energizes.
// - Open B on unload, immediate, key, A key cross or E/F alarm.
// - Opening B complete when B feedback reports open.
// - Leave B open state when B in range, no E/F, manual permit.
// - Unload B only two-breaker mode, same triggers as A.
// - Mode selects one breaker or two breakers; two is default.
`timescale 1ns/1ps
`include "breaker_defines.svh"
module breaker_ctrl
	import breaker_pkg::*;
#(
	parameter int DEV_NUM_W = `DEV_NUM_W_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic auto_mode,
	input wire logic two_breaker,
	input wire logic sys_a_ok,
	input wire logic sys_b_ok,
	input wire logic diff_ok,
	input wire logic two_connected,
	input wire logic variable_side,
	input wire logic alarm_c,
	input wire logic alarm_d,
	input wire logic alarm_e,
	input wire logic alarm_f,
	input wire logic enable_close_a,
	input wire logic open_unload_a,
	input wire logic open_immediate_a,
	input wire logic manual_close_a,
	input wire logic manual_open_a,
	input wire logic enable_close_b,
	input wire logic open_unload_b,
	input wire logic open_immediate_b,
	input wire logic manual_close_b,
	input wire logic manual_open_b,
	input wire logic man_unload_a,
	input wire logic man_unload_b,
	input wire logic relay_nc_a,
	input wire logic relay_nc_b,
	input wire logic cross_key_a,
	input wire logic cross_key_b,
	input wire logic key_a_pin,
	input wire logic key_b_pin,
	input wire logic fb_open_a_pin,
	input wire logic fb_open_b_pin,
	input wire logic open_fail_a,
	input wire logic open_fail_b,
	input wire logic unload_done_a,
	input wire logic unload_done_b,
	input wire logic [DEV_NUM_W-1:0] own_num,
	input wire logic peer_wish_any,
	input wire logic [DEV_NUM_W-1:0] peer_min_num,
	output logic sync_a,
	output logic sync_b,
	output logic relay_a,
	output logic relay_b,
	output logic unload_exec_a,
	output logic unload_exec_b,
	output logic open_wish
);

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	wire [`NUM_PIN-1:0] pin_raw = {fb_open_b_pin, fb_open_a_pin,
		key_b_pin, key_a_pin};
	logic [`NUM_PIN-1:0] meta_ff;
	logic [`NUM_PIN-1:0] pin_ff;

	// Two stages; only the second stage is read by logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			pin_ff <= '0;
		end else begin
			meta_ff <= pin_raw;
			pin_ff <= meta_ff;
		end
	end

	wire key_a = pin_ff[`PIN_KEY_A];
	wire key_b = pin_ff[`PIN_KEY_B];
	wire fb_a = pin_ff[`PIN_FB_A];
	wire fb_b = pin_ff[`PIN_FB_B];

	// ==========================================================
	// Shared conditions
	// ==========================================================
	wire man_mode = ~auto_mode;
	wire volt_ok = sys_a_ok & sys_b_ok & diff_ok;
	wire alarm_cd = alarm_c | alarm_d;
	wire alarm_ef = alarm_e | alarm_f;
	// Single mode counts every class from C upward
	wire alarm_open_a = two_breaker ? alarm_cd
		: (alarm_cd | alarm_ef);
	wire alarm_open_b = two_breaker & alarm_ef;
	wire unload_path = two_connected & variable_side;

	// ==========================================================
	// Per-breaker decision terms
	// ==========================================================
	wire [`NUM_CH-1:0] fb_open = {fb_b, fb_a};
	wire [`NUM_CH-1:0] sync_ok;
	wire [`NUM_CH-1:0] unl_trig;
	wire [`NUM_CH-1:0] key_trig;
	wire [`NUM_CH-1:0] imm_trig;
	wire [`NUM_CH-1:0] unl_ok;
	wire [`NUM_CH-1:0] abort_ok;
	wire [`NUM_CH-1:0] leave_ok;
	wire [`NUM_CH-1:0] fail = {open_fail_b, open_fail_a};
	wire [`NUM_CH-1:0] done = {unload_done_b, unload_done_a};
	wire [`NUM_CH-1:0] relay_nc = {relay_nc_b, relay_nc_a};

	// Sync permits; the breaker itself must still be open
	wire close_a = auto_mode
		? (enable_close_a & ~open_unload_a & ~open_immediate_a)
		: ((manual_close_a | key_a) & ~manual_open_a);
	wire close_b = auto_mode
		? (enable_close_b & ~open_unload_b & ~open_immediate_b)
		: ((manual_close_b | key_b) & ~manual_open_b);
	assign sync_ok[`CH_A] = volt_ok & close_a & fb_a
		& (~two_breaker | ~fb_b);
	assign sync_ok[`CH_B] = two_breaker & volt_ok & close_b & fb_b
		& ~fb_a;

	// Triggers that take the unloading path
	assign unl_trig[`CH_A] = auto_mode ? open_unload_a
		: (manual_open_a & man_unload_a);
	assign unl_trig[`CH_B] = two_breaker & (auto_mode ? open_unload_b
		: (manual_open_b & man_unload_b));
	// Soft key opens its own breaker, or the other one when allowed
	assign key_trig[`CH_A] = man_mode & (key_a
		| (two_breaker & cross_key_b & key_b));
	assign key_trig[`CH_B] = man_mode & two_breaker & (key_b
		| (cross_key_a & key_a));

	// Direct opens skip unloading altogether
	assign imm_trig[`CH_A] = alarm_open_a | (auto_mode
		? open_immediate_a
		: (manual_open_a & ~man_unload_a));
	assign imm_trig[`CH_B] = alarm_open_b | (two_breaker & (auto_mode
		? open_immediate_b
		: (manual_open_b & ~man_unload_b)));

	assign unl_ok[`CH_A] = unload_path;
	assign unl_ok[`CH_B] = two_breaker & unload_path;

	// Abort of a non-key unloading
	assign abort_ok[`CH_A] = auto_mode
		? (~open_unload_a & enable_close_a)
		: (~manual_open_a & manual_close_a);
	assign abort_ok[`CH_B] = auto_mode
		? (~open_unload_b & enable_close_b)
		: (~manual_open_b & manual_close_b);

	// Alternative exits from the open state
	assign leave_ok[`CH_A] = sys_a_ok & ~alarm_cd & (auto_mode
		? enable_close_a : (manual_close_a | key_a));
	assign leave_ok[`CH_B] = sys_b_ok & ~alarm_ef & (auto_mode
		? 1'b1 : ((manual_close_b | key_b) & ~manual_open_b));

	// ==========================================================
	// Open-wish negotiation
	// ==========================================================
	open_wish_if wif ();
	brk_state_e st_ff [`NUM_CH];
	logic [`NUM_CH-1:0] unloading;

	assign wif.wish = |unloading;

	open_wish_arbiter #(
		.DEV_NUM_W(DEV_NUM_W)
	) u_arb (
		.wif(wif),
		.own_num(own_num),
		.peer_wish_any(peer_wish_any),
		.peer_min_num(peer_min_num)
	);

	// ==========================================================
	// Per-breaker sequence
	// ==========================================================
	logic [`NUM_CH-1:0] key_held_ff;
	logic [`NUM_CH-1:0] sync_ff;
	logic [`NUM_CH-1:0] relay_ff;
	logic [`NUM_CH-1:0] exec_ff;
	logic [`NUM_CH-1:0] open_cmd;
	logic wish_ff;

	genvar i;
	generate
		for (i = 0; i < `NUM_CH; i++) begin : g_ch
			brk_state_e nxt_st;
			// A closed breaker is one whose feedback is not open
			wire closed = ~fb_open[i];
			wire any_unl = unl_trig[i] | key_trig[i];
			wire start_unl = closed & any_unl & unl_ok[i];
			wire go_open = closed & (imm_trig[i]
				| (any_unl & ~unl_ok[i]));
			wire nxt_key = (st_ff[i] == ST_IDLE) ? key_trig[i]
				: key_held_ff[i];
			// Key on an open breaker is a close permit, not an open
			wire nxt_sync = sync_ok[i] & (st_ff[i] == ST_IDLE)
				& ~(closed & any_unl) & ~imm_trig[i];
			wire nxt_exec = (nxt_st == ST_UNLOAD) & wif.grant
				& ~fail[i];

			assign unloading[i] = st_ff[i] == ST_UNLOAD;
			assign open_cmd[i] = nxt_st == ST_OPEN;

			// Next state; immediate opens overrule any unloading
			always_comb begin
				nxt_st = st_ff[i];
				case (st_ff[i])
					ST_IDLE: begin
						if (go_open)
							nxt_st = ST_OPEN;
						else if (start_unl)
							nxt_st = ST_UNLOAD;
					end
					ST_UNLOAD: begin
						if (imm_trig[i])
							nxt_st = ST_OPEN;
						else if (fail[i])
							nxt_st = ST_IDLE;
						else if (done[i] | fb_open[i])
							nxt_st = ST_OPEN;
						else if (abort_ok[i] & ~key_held_ff[i])
							nxt_st = ST_IDLE;
					end
					ST_OPEN: begin
						// Feedback or restored permit ends the command
						if (fb_open[i] | leave_ok[i])
							nxt_st = ST_IDLE;
					end
					default: nxt_st = ST_IDLE;
				endcase
			end

			// State and registered outputs of this breaker
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					st_ff[i] <= ST_IDLE;
					key_held_ff[i] <= `RST_OFF;
					sync_ff[i] <= `RST_OFF;
					relay_ff[i] <= `RST_OFF;
					exec_ff[i] <= `RST_OFF;
				end else begin
					st_ff[i] <= nxt_st;
					key_held_ff[i] <= nxt_key;
					sync_ff[i] <= nxt_sync;
					relay_ff[i] <= open_cmd[i] ^ relay_nc[i];
					exec_ff[i] <= nxt_exec;
				end
			end
		end
	endgenerate

	// Wish flag follows the published unloading state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wish_ff <= `RST_OFF;
		else
			wish_ff <= wif.wish;
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign sync_a = sync_ff[`CH_A];
	assign sync_b = sync_ff[`CH_B];
	assign relay_a = relay_ff[`CH_A];
	assign relay_b = relay_ff[`CH_B];
	assign unload_exec_a = exec_ff[`CH_A];
	assign unload_exec_b = exec_ff[`CH_B];
	assign open_wish = wish_ff;

	// ==========================================================
	// Assertions
	// ==========================================================
	sync_a_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		sync_a |-> $past(volt_ok) && $past(close_a) && $past(fb_a))
		else $error("sync A without permit");
	sync_b_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
		sync_b |-> $past(two_breaker) && !$past(fb_a))
		else $error("sync B outside two-breaker mode");
	sync_a_b_a: assert property (@(posedge clk) disable iff (!rst_n)
		(two_breaker && fb_b) |=> !sync_a)
		else $error("sync A with B open");
	open_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
		imm_trig[`CH_A] |=> !sync_a)
		else $error("sync A during open request");
	relay_pol_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_ff[`CH_A] == ST_OPEN) |-> relay_a != $past(relay_nc_a))
		else $error("relay A polarity wrong");
	relay_polb_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_ff[`CH_B] == ST_OPEN && !relay_nc_b) |-> relay_b)
		else $error("relay B not energized");
	fail_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
		open_fail_a |=> !unload_exec_a)
		else $error("unload runs during open failure");
	key_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(unloading[`CH_A] && key_held_ff[`CH_A] && !imm_trig[`CH_A]
		&& !fail[`CH_A] && !done[`CH_A] && !fb_a)
		|=> unloading[`CH_A])
		else $error("key unloading interrupted");
	fb_done_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_ff[`CH_A] == ST_OPEN && fb_a) |=> st_ff[`CH_A] == ST_IDLE)
		else $error("A open state kept after feedback");
	no_unl_b_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!two_breaker && st_ff[`CH_B] == ST_IDLE)
		|=> st_ff[`CH_B] != ST_UNLOAD)
		else $error("B unloads in single mode");
	alarm_a_a: assert property (@(posedge clk) disable iff (!rst_n)
		(alarm_c && !fb_a && st_ff[`CH_A] != ST_OPEN)
		|=> st_ff[`CH_A] == ST_OPEN)
		else $error("A not opened on class C alarm");

endmodule

// ==== logic/open_wish_arbiter.sv ====
// Open-wish negotiation against peers on the shared load share bus.
// Assumes peer flags arrive already decoded on the same clock.
`timescale 1ns/1ps
`include "breaker_defines.svh"
module open_wish_arbiter
	import breaker_pkg::*;
#(
	parameter int DEV_NUM_W = `DEV_NUM_W_DEF
) (
	open_wish_if.arb wif,
	input wire logic [DEV_NUM_W-1:0] own_num,
	input wire logic peer_wish_any,
	input wire logic [DEV_NUM_W-1:0] peer_min_num
);
	// Lowest device number among all requesters wins the execution
	wire smaller = own_num < peer_min_num;
	assign wif.grant = wif.wish & (~peer_wish_any | smaller);
endmodule

// ==== verification/breaker_ctrl_tb.sv ====
// Self-checking bench for the breaker control block.
// Assumes breaker_model stands in for breakers and genset side.
`timescale 1ns/1ps
module breaker_ctrl_tb;
	logic clk, rst_n;
	logic auto_mode, two_breaker, sys_a_ok, sys_b_ok, diff_ok, two_connected;
	logic variable_side, alarm_c, alarm_d, alarm_e, alarm_f;
	logic enable_close_a, open_unload_a, open_immediate_a, manual_close_a;
	logic manual_open_a, enable_close_b, open_unload_b, open_immediate_b;
	logic manual_close_b, manual_open_b, man_unload_a, man_unload_b;
	logic relay_nc_a, relay_nc_b, cross_key_a, cross_key_b;
	logic key_a_pin, key_b_pin, fb_open_a_pin, fb_open_b_pin;
	logic open_fail_a, open_fail_b, unload_done_a, unload_done_b;
	logic peer_wish_any;
	logic [5:0] own_num, peer_min_num;
	logic sync_a, sync_b, relay_a, relay_b;
	logic unload_exec_a, unload_exec_b, open_wish;
	logic [6:0] obs;
	string nm[7] = '{"sync_a", "sync_b", "relay_a", "relay_b",
		"unload_exec_a", "unload_exec_b", "open_wish"};
	int n_mismatch = 0;
	int n_tests = 0;

	// ==========================================
	// Block and far side
	breaker_ctrl #(.DEV_NUM_W(6)) uut (.clk, .rst_n, .auto_mode,
		.two_breaker, .sys_a_ok, .sys_b_ok, .diff_ok, .two_connected,
		.variable_side, .alarm_c, .alarm_d, .alarm_e, .alarm_f,
		.enable_close_a, .open_unload_a, .open_immediate_a, .manual_close_a,
		.manual_open_a, .enable_close_b, .open_unload_b, .open_immediate_b,
		.manual_close_b, .manual_open_b, .man_unload_a, .man_unload_b,
		.relay_nc_a, .relay_nc_b, .cross_key_a, .cross_key_b, .key_a_pin,
		.key_b_pin, .fb_open_a_pin, .fb_open_b_pin, .open_fail_a,
		.open_fail_b, .unload_done_a, .unload_done_b, .own_num,
		.peer_wish_any, .peer_min_num, .sync_a, .sync_b, .relay_a, .relay_b,
		.unload_exec_a, .unload_exec_b, .open_wish);
	breaker_model #(.DONE_CYC(12)) far_a (.clk, .rst_n, .relay(relay_a),
		.relay_nc(relay_nc_a), .sync(sync_a), .uexec(unload_exec_a),
		.fb_open(fb_open_a_pin), .done(unload_done_a));
	breaker_model #(.DONE_CYC(12)) far_b (.clk, .rst_n, .relay(relay_b),
		.relay_nc(relay_nc_b), .sync(sync_b), .uexec(unload_exec_b),
		.fb_open(fb_open_b_pin), .done(unload_done_b));
	assign obs = {open_wish, unload_exec_b, unload_exec_a, relay_b, relay_a,
		sync_b, sync_a};

	// ==========================================
	// Clock, tasks and verdict
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Inputs move 2 ns after the edge, so outputs are settled
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			#2;
		end
	endtask
	task automatic check(input int i, input logic v);
		n_tests++;
		if (obs[i] !== v) begin
			n_mismatch++;
			$display("[FAIL] %s expected %b seen %b", nm[i], v, obs[i]);
		end
	endtask
	// Bounded wait; a missed deadline shows up as one mismatch
	task automatic await(input int i, input logic v, input int lim);
		int k;
		k = 0;
		while (obs[i] !== v && k < lim) begin
			tick(1);
			k++;
		end
		check(i, v);
	endtask
	task automatic hold(input int i, input logic v, input int n);
		repeat (n) begin
			tick(1);
			check(i, v);
		end
	endtask
	task automatic conclude();
		$display("Tests %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Whole sequence needs at most 215 cycles
	initial begin
		#40000;
		n_mismatch++;
		conclude();
	end

	// ==========================================
	// Sequence
	initial begin
		rst_n = 1'b0;
		{auto_mode, two_breaker, sys_a_ok, sys_b_ok, diff_ok, two_connected,
			variable_side, alarm_c, alarm_d, alarm_e, alarm_f, enable_close_a,
			open_unload_a, open_immediate_a, manual_close_a, manual_open_a,
			enable_close_b, open_unload_b, open_immediate_b, manual_close_b,
			manual_open_b, man_unload_a, man_unload_b, relay_nc_a, relay_nc_b,
			cross_key_a, cross_key_b, key_a_pin, key_b_pin, open_fail_a,
			open_fail_b, peer_wish_any} = '0;
		own_num = 6'h05;
		peer_min_num = 6'h04;
		tick(3);
		for (int i = 0; i < 7; i++) check(i, 1'b0);
		rst_n = 1'b1;
		auto_mode = 1'b1;
		two_breaker = 1'b1;
		relay_nc_a = 1'b1;
		await(2, 1'b1, 4);
		// Trip B on its alarm class, A on class C, both in two-breaker mode
		alarm_e = 1'b1;
		await(3, 1'b1, 4);
		alarm_e = 1'b0;
		await(3, 1'b0, 8);
		alarm_c = 1'b1;
		await(2, 1'b0, 4);
		alarm_c = 1'b0;
		await(2, 1'b1, 8);
		// Sync A: blocked while B open in two-breaker mode
		{sys_a_ok, sys_b_ok, diff_ok, enable_close_a} = 4'hF;
		hold(0, 1'b0, 4);
		two_breaker = 1'b0;
		await(0, 1'b1, 4);
		open_immediate_a = 1'b1;
		await(0, 1'b0, 3);
		open_immediate_a = 1'b0;
		await(0, 1'b1, 8);
		tick(10);
		enable_close_a = 1'b0;
		// Sync B only in two-breaker mode with A closed
		enable_close_b = 1'b1;
		hold(1, 1'b0, 4);
		two_breaker = 1'b1;
		await(1, 1'b1, 4);
		tick(10);
		enable_close_b = 1'b0;
		// Unload A: start, abort, open failure, lower peer, completion
		{two_connected, variable_side} = 2'h3;
		open_unload_a = 1'b1;
		await(4, 1'b1, 4);
		await(6, 1'b1, 4);
		enable_close_a = 1'b1;
		open_unload_a = 1'b0;
		await(4, 1'b0, 4);
		enable_close_a = 1'b0;
		open_unload_a = 1'b1;
		await(4, 1'b1, 4);
		open_fail_a = 1'b1;
		await(4, 1'b0, 4);
		open_fail_a = 1'b0;
		await(4, 1'b1, 5);
		peer_wish_any = 1'b1;
		await(4, 1'b0, 4);
		peer_min_num = 6'h06;
		await(4, 1'b1, 4);
		await(2, 1'b0, 20);
		open_unload_a = 1'b0;
		await(2, 1'b1, 8);
		// B without two connected systems opens straight away
		{two_connected, sys_b_ok} = 2'h0;
		open_unload_b = 1'b1;
		await(3, 1'b1, 4);
		check(5, 1'b0);
		open_unload_b = 1'b0;
		await(3, 1'b0, 8);
		// Manual: soft key permits sync, manual open withdraws it
		{auto_mode, two_breaker, sys_b_ok} = 3'h1;
		key_a_pin = 1'b1;
		await(0, 1'b1, 6);
		manual_open_a = 1'b1;
		await(0, 1'b0, 3);
		// Close A on the manual input, then unload it from the soft key
		{manual_open_a, key_a_pin, manual_close_a} = 3'h1;
		await(0, 1'b1, 4);
		await(0, 1'b0, 12);
		two_connected = 1'b1;
		key_a_pin = 1'b1;
		await(4, 1'b1, 6);
		key_a_pin = 1'b0;
		// Abort inputs stand, yet a key-started unload keeps going
		hold(4, 1'b1, 4);
		check(6, 1'b1);
		manual_close_a = 1'b0;
		await(2, 1'b0, 16);
		await(2, 1'b1, 8);
		// Reset in mid-run clears every output, then NC idle returns
		rst_n = 1'b0;
		tick(1);
		for (int i = 0; i < 7; i++) check(i, 1'b0);
		rst_n = 1'b1;
		await(2, 1'b1, 4);
		conclude();
	end
endmodule

// ==== verification/breaker_model.sv ====
// Far-side model of one breaker and the genset side that unloads it.
// Assumes one clk domain; feedback reaches the pin synchroniser.
`timescale 1ns/1ps
module breaker_model #(
	parameter int DONE_CYC = 12
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic relay,
	input wire logic relay_nc,
	input wire logic sync,
	input wire logic uexec,
	output logic fb_open,
	output logic done
);
	// ==========================================
	// Contacts
	logic open_cmd;
	logic cmd_ff;
	logic [3:0] sync_cnt_ff;
	logic [7:0] exec_cnt_ff;

	// Coil sees the command through the relay polarity
	assign open_cmd = relay ^ relay_nc;
	// Trip only on a command standing two edges; the mechanism ignores
	// the one-cycle glitch of a polarity change. Close after steady sync
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fb_open <= 1'b0;
			cmd_ff <= 1'b0;
			sync_cnt_ff <= 4'h0;
		end else begin
			cmd_ff <= open_cmd;
			sync_cnt_ff <= (sync && !open_cmd) ? sync_cnt_ff + 4'h1 : 4'h0;
			if (open_cmd && cmd_ff) begin
				fb_open <= 1'b1;
			end else if (sync_cnt_ff == 4'h5) begin
				fb_open <= 1'b0;
			end
		end
	end

	// ==========================================
	// Genset side
	// Done only after an unbroken hand-over; any drop restarts it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			exec_cnt_ff <= 8'h00;
		end else begin
			exec_cnt_ff <= uexec ? exec_cnt_ff + 8'h01 : 8'h00;
		end
	end
	assign done = (exec_cnt_ff >= 8'(DONE_CYC));
endmodule
